// *** common/eeprom_consts.svh ***
// Constants for the two-wire serial EEPROM slave front end
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// =====================================================================
// Array shape
`define EE_MEM_BYTES      4096
`define EE_ADDR_W         12
`define EE_PAGE_BYTES     32
`define EE_PAGE_W         5
`define EE_ADDR_HI_W      4

// =====================================================================
// Protocol fields
`define EE_DEV_CODE       4'ha
`define EE_LAST_BIT       4'h8

// =====================================================================
// Reset values
`define EE_SDA_OE_N_RST   1'b1
`define EE_SDA_OUT_RST    1'b0

// =====================================================================
// Timing
`define EE_WRITE_TIME_MS  5
`define EE_CORE_CLK_MHZ   100
`define EE_WRITE_CYCLES   (`EE_WRITE_TIME_MS * 1000 * `EE_CORE_CLK_MHZ)

`endif

// *** common/eeprom_pkg.sv ***
// Types for the two-wire serial EEPROM slave front end
package eeprom_pkg;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_DEV_ADDR,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WR_DATA,
		ST_RD_DATA,
		ST_RD_ACK,
		ST_WAIT_STOP,
		ST_PROGRAM
	} link_state_t;
	typedef logic [11:0] word_addr_t;
	typedef logic [7:0]  data_byte_t;
endpackage : eeprom_pkg

// *** core/serial_eeprom_slave_interface.sv ***
// Two-wire serial EEPROM slave: protocol engine, page buffer and array
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_consts.svh"

module serial_eeprom_slave_interface
	import eeprom_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES
)(
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	// Two-wire bus
	input  wire logic i_scl,
	input  wire logic i_sda_in,
	output var  logic o_sda_out,
	output var  logic o_sda_oe_n,
	// Straps
	input  wire logic i_chip_select_strap_high,
	input  wire logic i_chip_select_strap_mid,
	input  wire logic i_chip_select_strap_low,
	input  wire logic i_write_protect,
	// Status
	output var  logic o_busy,
	output var  logic o_standby
);

	// =================================================================
	// Functions
	function automatic word_addr_t next_addr(input word_addr_t a);
		next_addr = a + 12'h001;
	endfunction : next_addr

	function automatic logic in_rx(input link_state_t s);
		in_rx = (s == ST_DEV_ADDR) || (s == ST_ADDR_HI) ||
			(s == ST_ADDR_LO) || (s == ST_WR_DATA);
	endfunction : in_rx

	// =================================================================
	// Pin synchronisers
	logic [5:0]           pins_meta_q;
	logic [5:0]           pins_sync_q;
	logic                 scl_prev_q;
	logic                 sda_prev_q;
	logic                 scl_s;
	logic                 sda_s;
	logic                 wp_s;
	logic [2:0]           strap_s;
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 start_det;
	logic                 stop_det;

	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pins_meta_q <= 6'h30;
			pins_sync_q <= 6'h30;
			scl_prev_q  <= 1'b1;
			sda_prev_q  <= 1'b1;
		end
		else
		begin
			pins_meta_q <= {i_scl, i_sda_in, i_write_protect,
				i_chip_select_strap_high, i_chip_select_strap_mid,
				i_chip_select_strap_low};
			pins_sync_q <= pins_meta_q;
			scl_prev_q  <= scl_s;
			sda_prev_q  <= sda_s;
		end
	end

	assign scl_s     = pins_sync_q[5];
	assign sda_s     = pins_sync_q[4];
	assign wp_s      = pins_sync_q[3];
	assign strap_s   = pins_sync_q[2:0];
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// =================================================================
	// Protocol state
	link_state_t          state_q;
	logic [3:0]           bit_cnt_q;
	data_byte_t           shift_q;
	data_byte_t           tx_q;
	logic                 ack_q;
	logic                 rw_q;
	logic                 mack_q;
	word_addr_t           addr_q;
	logic [3:0]           addr_hi_q;
	logic [31:0]          page_mask_q;
	logic [31:0]          prog_cnt_q;
	logic [5:0]           commit_idx_q;
	logic                 oe_n_q;
	logic                 sda_out_q;
	logic                 busy_q;
	logic                 standby_q;

	// Storage
	data_byte_t           mem [0:`EE_MEM_BYTES-1];
	data_byte_t           page_buf [0:`EE_PAGE_BYTES-1];

	logic                 byte_done;
	logic                 ack_end;
	logic                 dev_hit;
	logic                 prog_req;
	logic                 prog_done;
	logic                 commit_we;
	data_byte_t           rd_byte;

	assign byte_done = scl_fall & in_rx(state_q) & ~ack_q &
		(bit_cnt_q == `EE_LAST_BIT);
	assign ack_end   = scl_fall & ack_q;
	assign dev_hit   = (shift_q[7:4] == `EE_DEV_CODE) &&
		(shift_q[3:1] == strap_s);
	// A STOP with nothing buffered, or with protect high, starts no cycle
	assign prog_req  = stop_det & (state_q == ST_WR_DATA) &
		(page_mask_q != 32'h0) & ~wp_s;
	assign prog_done = (prog_cnt_q == WRITE_CYCLES - 1);
	assign commit_we = (state_q == ST_PROGRAM) & ~commit_idx_q[5] &
		page_mask_q[commit_idx_q[4:0]];
	assign rd_byte   = mem[addr_q];

	// =================================================================
	// Main sequencer
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state_q      <= ST_IDLE;
			bit_cnt_q    <= 4'h0;
			shift_q      <= 8'h00;
			tx_q         <= 8'h00;
			ack_q        <= 1'b0;
			rw_q         <= 1'b0;
			mack_q       <= 1'b0;
			addr_q       <= 12'h000;
			addr_hi_q    <= 4'h0;
			page_mask_q  <= 32'h0;
			prog_cnt_q   <= 32'h0;
			commit_idx_q <= 6'h00;
			oe_n_q       <= `EE_SDA_OE_N_RST;
			busy_q       <= 1'b0;
		end
		else if (state_q == ST_PROGRAM)
		begin
			// Bus is deaf here: no START, STOP or acknowledge
			oe_n_q     <= 1'b1;
			prog_cnt_q <= prog_cnt_q + 32'h1;
			if (!commit_idx_q[5])
				commit_idx_q <= commit_idx_q + 6'h01;
			if (prog_done)
			begin
				state_q <= ST_IDLE;
				busy_q  <= 1'b0;
			end
		end
		else if (start_det)
		begin
			// Any START outside ST_PROGRAM aborts the transfer; covers the recovery sequence
			state_q   <= ST_DEV_ADDR;
			bit_cnt_q <= 4'h0;
			ack_q     <= 1'b0;
			oe_n_q    <= 1'b1;
		end
		else if (stop_det)
		begin
			oe_n_q <= 1'b1;
			ack_q  <= 1'b0;
			if (prog_req)
			begin
				state_q      <= ST_PROGRAM;
				prog_cnt_q   <= 32'h0;
				commit_idx_q <= 6'h00;
				busy_q       <= 1'b1;
			end
			else
				state_q <= ST_IDLE;
		end
		else if (scl_rise && in_rx(state_q) && bit_cnt_q < `EE_LAST_BIT)
		begin
			shift_q   <= {shift_q[6:0], sda_s};
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
		else if (byte_done)
		begin
			ack_q  <= 1'b1;
			oe_n_q <= 1'b0;
			case (state_q)
				ST_DEV_ADDR:
				begin
					rw_q <= shift_q[0];
					if (!dev_hit)
					begin
						state_q <= ST_IDLE;
						ack_q   <= 1'b0;
						oe_n_q  <= 1'b1;
					end
				end
				ST_ADDR_HI: addr_hi_q <= shift_q[3:0];
				ST_ADDR_LO:
				begin
					addr_q      <= {addr_hi_q, shift_q};
					page_mask_q <= 32'h0;
				end
				ST_WR_DATA:
				begin
					page_mask_q[addr_q[4:0]] <= 1'b1;
					addr_q <= {addr_q[11:5], addr_q[4:0] + 5'h01};
				end
				default: ;
			endcase
		end
		else if (ack_end)
		begin
			ack_q     <= 1'b0;
			bit_cnt_q <= 4'h0;
			oe_n_q    <= 1'b1;
			case (state_q)
				ST_DEV_ADDR:
					if (rw_q)
					begin
						state_q <= ST_RD_DATA;
						tx_q    <= rd_byte;
						oe_n_q  <= rd_byte[7];
						addr_q  <= next_addr(addr_q);
					end
					else
						state_q <= ST_ADDR_HI;
				ST_ADDR_HI: state_q <= ST_ADDR_LO;
				default:    state_q <= ST_WR_DATA;
			endcase
		end
		else
		begin
			case (state_q)
				ST_RD_DATA:
					if (scl_rise)
						bit_cnt_q <= bit_cnt_q + 4'h1;
					else if (scl_fall && bit_cnt_q == `EE_LAST_BIT)
					begin
						oe_n_q  <= 1'b1;
						mack_q  <= 1'b0;
						state_q <= ST_RD_ACK;
					end
					else if (scl_fall)
					begin
						oe_n_q <= tx_q[6];
						tx_q   <= {tx_q[6:0], 1'b0};
					end
				ST_RD_ACK:
					if (scl_rise && sda_s)
						state_q <= ST_WAIT_STOP;
					else if (scl_rise)
						mack_q <= 1'b1;
					else if (scl_fall && mack_q)
					begin
						state_q   <= ST_RD_DATA;
						bit_cnt_q <= 4'h0;
						tx_q      <= rd_byte;
						oe_n_q    <= rd_byte[7];
						addr_q    <= next_addr(addr_q);
					end
				default: ;
			endcase
		end
	end

	// Array and page buffer carry no reset; contents survive a bus abort
	always_ff @(posedge i_core_clk)
	begin
		if (byte_done && state_q == ST_WR_DATA)
			page_buf[addr_q[4:0]] <= shift_q;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (commit_we)
			mem[{addr_q[11:5], commit_idx_q[4:0]}] <=
				page_buf[commit_idx_q[4:0]];
	end

	// =================================================================
	// Outputs
	always_ff @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			sda_out_q <= `EE_SDA_OUT_RST;
			standby_q <= 1'b1;
		end
		else
		begin
			sda_out_q <= `EE_SDA_OUT_RST;
			standby_q <= (state_q == ST_IDLE);
		end
	end

	assign o_sda_out  = sda_out_q;
	assign o_sda_oe_n = oe_n_q;
	assign o_busy     = busy_q;
	assign o_standby  = standby_q;

	// =================================================================
	// Assertions
	sequence s_byte_in;
		byte_done && state_q == ST_DEV_ADDR;
	endsequence

	sequence s_write_stop;
		stop_det && state_q == ST_WR_DATA;
	endsequence

	a_ack_drives_low: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		ack_q |-> !o_sda_oe_n)
		else $error("acknowledge phase without data line pulled low");

	a_mismatch_no_ack: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		s_byte_in ##0 !dev_hit |=> state_q == ST_IDLE && o_sda_oe_n)
		else $error("unmatched device address was acknowledged");

	a_busy_silent: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		o_busy |=> o_sda_oe_n)
		else $error("data line driven during programming");

	a_protect_blocks: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		s_write_stop ##0 wp_s |=> !o_busy ##1 !o_busy)
		else $error("programming started while write protect high");

	a_write_launches: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		s_write_stop ##0 (page_mask_q != 32'h0) && !wp_s
		|=> o_busy && !o_standby)
		else $error("write STOP did not launch programming");

	a_prog_bounded: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		o_busy |-> prog_cnt_q < WRITE_CYCLES)
		else $error("programming cycle overran its time");

	a_standby_after: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		$fell(o_busy) |-> ##1 o_standby)
		else $error("no standby after programming");

	a_change_on_fall: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		$changed(o_sda_oe_n) && !$past(o_busy)
		|-> $past(scl_fall || start_det || stop_det))
		else $error("data line changed away from a clock fall");

	a_start_restarts: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		start_det && !o_busy |=> state_q == ST_DEV_ADDR && bit_cnt_q == 0)
		else $error("START did not restart address reception");

	a_read_stop_idle: assert property (
		@(posedge i_core_clk) disable iff (i_sys_rst)
		stop_det && state_q == ST_WAIT_STOP |=> ##1 o_standby)
		else $error("read STOP did not return to standby");

endmodule : serial_eeprom_slave_interface
`default_nettype wire

// *** sim/bus_master_model.sv ***
// Behavioural two-wire bus master that drives the link clock and data
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	// Two-wire bus, 1 on o_sda means released
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda
);
	// Extra low time in ns, so a slow master can be played
	int slow = 0;
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// =====================================================
	// Framing
	task automatic start_cond();
		o_sda = 1'b1;
		#40 o_scl = 1'b1;
		#40 o_sda = 1'b0;
		#40 o_scl = 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		#20 o_sda = 1'b0;
		#40 o_scl = 1'b1;
		#40 o_sda = 1'b1;
		#60;
	endtask : stop_cond
	// =====================================================
	// Bits and bytes, 125 ns a bit; clock stands high between frames
	task automatic clk_bit(input logic b, output logic r);
		#(20 + slow) o_sda = b;
		#42 o_scl = 1'b1;
		#31 r = i_sda;
		#32 o_scl = 1'b0;
	endtask : clk_bit
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], r);
		clk_bit(1'b1, ack);
	endtask : send_byte
	task automatic recv_byte(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'b1, d[i]);
		clk_bit(nack, r);
	endtask : recv_byte
endmodule : bus_master_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the serial EEPROM slave front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import eeprom_pkg::*;
	localparam int unsigned WCYC = 200;
	localparam logic [6:0] DEV = 7'h55;
	logic core_clk;
	logic sys_rst;
	logic strap_h;
	logic strap_m;
	logic strap_l;
	logic wp;
	wire  scl;
	wire  m_sda;
	wire  sda_bus;
	wire  sda_out;
	wire  sda_oe_n;
	wire  busy;
	wire  standby;
	int   cyc = 0;
	int   n_mismatch = 0;
	int   n_checks = 0;
	// Pull-up wired-AND of both open-drain parties
	assign sda_bus = m_sda & (sda_oe_n | sda_out);
	serial_eeprom_slave_interface #(.WRITE_CYCLES(WCYC))
	u_serial_eeprom_slave_interface (
		.i_core_clk(core_clk), .i_sys_rst(sys_rst),
		.i_scl(scl), .i_sda_in(sda_bus),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
		.i_chip_select_strap_high(strap_h),
		.i_chip_select_strap_mid(strap_m),
		.i_chip_select_strap_low(strap_l),
		.i_write_protect(wp), .o_busy(busy), .o_standby(standby)
	);
	bus_master_model u_bus_master_model (
		.i_sda(sda_bus), .o_scl(scl), .o_sda(m_sda)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;
	// =====================================================
	// Compare and verdict
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_byte(input data_byte_t got, input data_byte_t exp);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, n_checks);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	// =====================================================
	// Bus sequences
	task automatic cmd(input logic [7:0] d, input logic exp);
		logic ack;
		u_bus_master_model.send_byte(d, ack);
		chk_bit(ack, exp);
	endtask : cmd
	task automatic set_addr(input word_addr_t a, input logic [3:0] junk);
		u_bus_master_model.start_cond();
		cmd({DEV, 1'b0}, 1'b0);
		cmd({junk, a[11:8]}, 1'b0);
		cmd(a[7:0], 1'b0);
	endtask : set_addr
	task automatic wait_prog(input logic exp);
		int c0;
		c0 = cyc;
		while (busy !== 1'b1 && cyc < c0 + 20)
			@(negedge core_clk);
		chk_bit(busy, exp);
		if (exp)
		begin
			c0 = cyc;
			u_bus_master_model.start_cond();
			cmd({DEV, 1'b0}, 1'b1);
			u_bus_master_model.stop_cond();
			chk_bit(standby, 1'b0);
			while (cyc < c0 + WCYC - 4)
				@(negedge core_clk);
			chk_bit(busy, 1'b1);
			while (cyc < c0 + WCYC + 4)
				@(negedge core_clk);
			chk_bit(busy, 1'b0);
		end
		chk_bit(standby, 1'b1);
	endtask : wait_prog
	task automatic wr(input word_addr_t a, input int n, input data_byte_t b);
		set_addr(a, 4'hf);
		for (int i = 0; i < n; i++)
			cmd(b + i[7:0], 1'b0);
		u_bus_master_model.stop_cond();
		wait_prog(~wp);
	endtask : wr
	task automatic rd(input word_addr_t a, input int n, input data_byte_t b);
		data_byte_t d;
		set_addr(a, 4'h0);
		u_bus_master_model.start_cond();
		cmd({DEV, 1'b1}, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			u_bus_master_model.recv_byte(i == n - 1, d);
			chk_byte(d, b + i[7:0]);
		end
		u_bus_master_model.stop_cond();
	endtask : rd
	// =====================================================
	// Scenarios
	task automatic t_write_read();
		wr(12'h123, 1, 8'h5a);
		rd(12'h123, 1, 8'h5a);
		wr(12'h01f, 2, 8'h30);
		wr(12'hfff, 1, 8'h30);
		rd(12'hfff, 2, 8'h30);
	endtask : t_write_read
	task automatic t_protect();
		@(posedge core_clk) wp <= 1'b1;
		wr(12'h01f, 1, 8'h99);
		u_bus_master_model.slow = 150;
		rd(12'h01f, 1, 8'h30);
		u_bus_master_model.slow = 0;
		@(posedge core_clk) wp <= 1'b0;
	endtask : t_protect
	task automatic t_select();
		logic [7:0] d;
		u_bus_master_model.start_cond();
		cmd(8'hba, 1'b1);
		u_bus_master_model.start_cond();
		cmd(8'ha8, 1'b1);
		u_bus_master_model.stop_cond();
		@(posedge core_clk)
		begin
			strap_h <= 1'b0;
			strap_l <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		u_bus_master_model.start_cond();
		cmd(8'ha1, 1'b0);
		u_bus_master_model.recv_byte(1'b1, d);
		u_bus_master_model.stop_cond();
		chk_bit(standby, 1'b1);
		@(posedge core_clk)
		begin
			strap_h <= 1'b1;
			strap_l <= 1'b1;
		end
	endtask : t_select
	task automatic t_soft_reset();
		logic r;
		u_bus_master_model.start_cond();
		cmd({DEV, 1'b0}, 1'b0);
		u_bus_master_model.start_cond();
		for (int i = 0; i < 18; i++)
			u_bus_master_model.clk_bit(1'b1, r);
		u_bus_master_model.start_cond();
		cmd({DEV, 1'b0}, 1'b0);
		u_bus_master_model.stop_cond();
		rd(12'h000, 1, 8'h31);
	endtask : t_soft_reset
	initial
	begin
		sys_rst = 1'b1;
		strap_h = 1'b1;
		strap_m = 1'b0;
		strap_l = 1'b1;
		wp = 1'b0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		chk_bit(sda_oe_n, 1'b1);
		chk_bit(sda_out, 1'b0);
		chk_bit(busy, 1'b0);
		chk_bit(standby, 1'b1);
		repeat (4) @(posedge core_clk);
		t_write_read();
		t_protect();
		t_select();
		t_soft_reset();
		give_verdict();
	end
	// Roughly 50 bytes of traffic and three programming cycles
	initial
	begin
		#400us;
		n_mismatch++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
